// *** mta_core.sv ***
// register, conversion and alarm core of the temperature monitor
`timescale 1ns/1ps
module mta_core #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,
  // arbitrary identification value
  parameter logic [7:0] MFR_ID     = 8'h5b,
  parameter int         FAULT_CYC  = mta_pkg::FAULT_CYC,
  parameter int         TMO_CYC    = mta_pkg::BUS_TMO_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output wire logic                      sda_o,
  output wire logic                      sda_oe_o,
  output wire logic                      alert_n_o,
  output wire logic                      alert_oe_o,
  output wire logic                      overtemp_shutdown_output_n_o,
  output wire logic                      overtemp_shutdown_output_oe_o,
  output wire logic                      res_cancel_en_o,
  output wire logic                      beta_comp_en_o,
  input  wire logic                      conv_clk_i,
  output wire logic                      adc_start_o,
  output wire logic [2:0]                adc_chan_o,
  input  wire logic                      adc_done_i,
  input  wire logic [mta_pkg::ADC_W-1:0] adc_data_i,
  input  wire logic                      adc_fault_i
);
  localparam int N = mta_pkg::NCH;

  if (FAULT_CYC < 1 || TMO_CYC < 1 ||
      FAULT_CYC >= 2 ** mta_pkg::CNT_W || TMO_CYC >= 2 ** mta_pkg::CNT_W)
  begin : g_chk
    $error("count parameter out of range");
  end

  typedef enum logic [2:0] {
    Q_IDLE = 3'b001, Q_REQ = 3'b010, Q_DROP = 3'b100
  } mta_seq_t;

  mta_pkg::mta_smb_evt_t     ev;
  mta_pkg::mta_conv_t        cap_q;
  mta_seq_t                  seq_q;
  logic                      soft_rst_q, rst_all;
  logic [7:0]                ptr_q, cfg1_q, cfg2_q, cfg3_q, rd_data;
  logic [N-1:0][7:0]         temp_q, alim_q, olim_q;
  logic [2:0]                ext_q, seq_ch_q, slot, pch;
  logic [N-1:0]              ast_q, ot_q, fault_q, amask, omask;
  logic [N-1:0]              hit_al, ot_set, ot_clr, ch_sel;
  logic                      alert_q, ot_out_q, hold_q;
  logic [mta_pkg::CNT_W-1:0] hold_cnt_q, wd_q;
  logic                      req_q, res_ev, tmo_ev, res_valid, res_fault;
  logic                      wr, rd, grp_ok, clr_st1;
  logic [8:0]                whole;
  logic [7:0]                res_main;
  logic [2:0]                res_ext;
  logic [1:0]                ack_ff_q, creq_ff_q, cce_ff_q, crst_ff_q;
  logic                      ack_s, cbusy_q, cack_q, cstart_q;
  logic [2:0]                cchan_q;

  assign rst_all = rst_i | soft_rst_q;
  assign wr      = ev.data_wr;
  assign rd      = ev.rd_done;
  assign slot    = ptr_q[2:0];
  assign pch     = (slot == mta_pkg::LOCAL_SLOT) ? 3'h0 : slot;
  assign grp_ok  = slot != 3'h0;
  assign clr_st1 = rd && ptr_q == mta_pkg::A_ST1;
  // bit 6 local, bits 5..0 remote 6..1
  assign amask = {cfg2_q[5:0], cfg2_q[6]};
  assign omask = {cfg3_q[5:3], 2'b00, cfg3_q[0], 1'b0};

  mta_smb_slave #(
    .SLAVE_ADDR (SLAVE_ADDR),
    .TMO_CYC    (TMO_CYC)
  ) u_slave (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o),
    .tmo_en_i  (~cfg1_q[mta_pkg::CFG1_TMO]),
    .alert_i   (alert_q),
    .rd_data_i (rd_data),
    .evt_o     (ev)
  );

  // one-cycle soft reset, bit never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) soft_rst_q <= 1'b0;
    else if (ce_i)
      soft_rst_q <= wr && ptr_q == mta_pkg::A_CFG1 &&
                    ev.data[mta_pkg::CFG1_POR];
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) ptr_q <= mta_pkg::PTR_RST;
    else if (ce_i && ev.ptr_wr) ptr_q <= ev.data;
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      cfg1_q <= mta_pkg::CFG1_RST;
      cfg2_q <= mta_pkg::CFG2_RST;
      cfg3_q <= mta_pkg::CFG3_RST;
      alim_q <= mta_pkg::ALIM_RST;
      olim_q <= mta_pkg::OLIM_RST;
    end else if (ce_i && wr) begin
      // only stop, timeout and compensation bits kept
      if (ptr_q == mta_pkg::A_CFG1) cfg1_q <= ev.data & mta_pkg::CFG1_MASK;
      if (ptr_q == mta_pkg::A_CFG2) cfg2_q <= ev.data & mta_pkg::CFG2_MASK;
      if (ptr_q == mta_pkg::A_CFG3) cfg3_q <= ev.data & mta_pkg::CFG3_MASK;
      // seven alert and four overtemp limits
      if (grp_ok && ptr_q[7:3] == mta_pkg::GRP_ALIM) alim_q[pch] <= ev.data;
      if (grp_ok && ptr_q[7:3] == mta_pkg::GRP_OLIM &&
          mta_pkg::OT_CHANS[pch])
        olim_q[pch] <= ev.data;
    end
  end

  // receive byte returns the pointed register
  always_comb begin
    rd_data = 8'h00;
    case (ptr_q)
      // fraction in bits 7:5, low bits zero
      mta_pkg::A_EXT:  rd_data = {ext_q, 5'h00};
      mta_pkg::A_MFR:  rd_data = MFR_ID;
      mta_pkg::A_CFG1: rd_data = cfg1_q;
      mta_pkg::A_CFG2: rd_data = cfg2_q;
      mta_pkg::A_CFG3: rd_data = cfg3_q;
      mta_pkg::A_ST1:  rd_data = {1'b0, ast_q[0], ast_q[6:1]};
      mta_pkg::A_ST2:  rd_data = {2'b00, ot_q[6:4], 2'b00, ot_q[1]};
      mta_pkg::A_ST3:  rd_data = {2'b00, fault_q[6:1]};
      default: begin
        if (grp_ok && ptr_q[7:3] == mta_pkg::GRP_TEMP)
          rd_data = temp_q[pch];
        else if (grp_ok && ptr_q[7:3] == mta_pkg::GRP_ALIM)
          rd_data = alim_q[pch];
        else if (grp_ok && ptr_q[7:3] == mta_pkg::GRP_OLIM &&
                 mta_pkg::OT_CHANS[pch])
          rd_data = olim_q[pch];
      end
    endcase
  end

  // conversion request crosses by a four-phase handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_ff_q <= 2'b00;
    else if (ce_i) ack_ff_q <= {ack_ff_q[0], cack_q};
  end
  assign ack_s = ack_ff_q[1];

  always_ff @(posedge conv_clk_i) begin
    creq_ff_q <= {creq_ff_q[0], req_q};
    cce_ff_q  <= {cce_ff_q[0], ce_i};
    crst_ff_q <= {crst_ff_q[0], rst_all};
  end

  always_ff @(posedge conv_clk_i) begin
    if (crst_ff_q[1]) begin
      cbusy_q  <= 1'b0;
      cack_q   <= 1'b0;
      cstart_q <= 1'b0;
      // channel kept: a start just issued must still see it
      cap_q    <= '0;
    end else if (cce_ff_q[1]) begin
      cstart_q <= 1'b0;
      if (creq_ff_q[1] && !cbusy_q && !cack_q) begin
        cbusy_q  <= 1'b1;
        cstart_q <= 1'b1;
        cchan_q  <= seq_ch_q;
      end else if (cbusy_q && adc_done_i) begin
        cbusy_q <= 1'b0;
        cack_q  <= 1'b1;
        cap_q   <= {adc_data_i, adc_fault_i};
      end else if (cack_q && !creq_ff_q[1]) begin
        cack_q <= 1'b0;
      end
    end
  end
  assign adc_start_o = cstart_q;
  assign adc_chan_o  = cchan_q;

  assign res_ev    = seq_q == Q_REQ && ack_s;
  assign tmo_ev    = seq_q == Q_REQ && !ack_s &&
                     wd_q == mta_pkg::CNT_W'(FAULT_CYC - 1);
  // reported open diode or silent front end
  assign res_fault = tmo_ev || (res_ev && cap_q.fault);
  assign res_valid = res_ev && !cap_q.fault;
  assign ch_sel    = N'(1) << seq_ch_q;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      seq_q    <= Q_IDLE;
      seq_ch_q <= 3'h0;
      req_q    <= 1'b0;
      wd_q     <= '0;
    end else if (ce_i) begin
      case (seq_q)
        Q_IDLE: begin
          wd_q <= '0;
          if (!cfg1_q[mta_pkg::CFG1_STOP] && !ack_s) begin
            req_q <= 1'b1;
            seq_q <= Q_REQ;
          end
        end
        Q_REQ: begin
          wd_q <= wd_q + 1'b1;
          // result or fault, then next channel
          if (res_ev || tmo_ev) begin
            req_q    <= 1'b0;
            seq_ch_q <= (seq_ch_q == 3'(N - 1)) ? 3'h0 : seq_ch_q + 3'h1;
            seq_q    <= Q_DROP;
          end
        end
        Q_DROP: if (!ack_s) seq_q <= Q_IDLE;
        default: seq_q <= Q_IDLE;
      endcase
    end
  end

  // 1/8 degree result, integer part in 11:3
  assign whole = cap_q.data[mta_pkg::ADC_W-1:3];
  // negative reads zero, above 127 saturates
  always_comb begin
    res_main = whole[7:0];
    res_ext  = cap_q.data[2:0];
    if (whole[8]) begin
      res_main = mta_pkg::TEMP_MIN;
      res_ext  = 3'h0;
    end else if (whole[7]) begin
      res_main = mta_pkg::TEMP_MAX;
      res_ext  = 3'h0;
    end
  end

  for (genvar c = 0; c < N; c++) begin : g_ch
    assign hit_al[c] = res_valid && ch_sel[c] && res_main > alim_q[c];
    assign ot_set[c] = res_valid && ch_sel[c] && mta_pkg::OT_CHANS[c] &&
                       res_main > olim_q[c];
    assign ot_clr[c] = res_valid && ch_sel[c] &&
                       {1'b0, res_main} + mta_pkg::OT_HYST <
                       {1'b0, olim_q[c]};
  end

  // extended read freezes channel 1 until its main byte is read or TMO_CYC cycles pass
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      hold_q     <= 1'b0;
      hold_cnt_q <= '0;
    end else if (ce_i) begin
      hold_cnt_q <= hold_q ? hold_cnt_q + 1'b1 : '0;
      if (rd && ptr_q == mta_pkg::A_EXT) begin
        hold_q     <= 1'b1;
        hold_cnt_q <= '0;
      end else if ((rd && ptr_q == mta_pkg::A_TEMP1) ||
                   hold_cnt_q == mta_pkg::CNT_W'(TMO_CYC - 1)) begin
        hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      temp_q  <= {N{mta_pkg::TEMP_RST}};
      ext_q   <= 3'h0;
      fault_q <= '0;
    end else if (ce_i && (res_valid || res_fault) &&
                 !(hold_q && seq_ch_q == 3'h1)) begin
      // fault code stored, fault bit set
      temp_q[seq_ch_q] <= res_fault ? mta_pkg::TEMP_FAULT : res_main;
      if (seq_ch_q == 3'h1 && res_valid) ext_q <= res_ext;
    end
    if (!rst_all && ce_i) begin
      if (res_fault) fault_q <= fault_q | ch_sel;
      else if (res_valid) fault_q <= fault_q & ~ch_sel;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      ast_q    <= '0;
      alert_q  <= 1'b0;
      ot_q     <= '0;
      ot_out_q <= 1'b0;
    end else if (ce_i) begin
      ast_q <= (ast_q & ~{N{clr_st1}}) | hit_al;
      // status read or won response clears
      // a lost response keeps alert held
      alert_q <= (alert_q & ~(clr_st1 | ev.ara_won)) |
                 (|(hit_al & ~amask));
      ot_q     <= (ot_q & ~ot_clr) | ot_set;
      ot_out_q <= |(((ot_q & ~ot_clr) | ot_set) & ~omask);
    end
  end

  assign alert_n_o                     = 1'b0;
  assign alert_oe_o                    = alert_q;
  assign overtemp_shutdown_output_n_o  = 1'b0;
  assign overtemp_shutdown_output_oe_o = ot_out_q;
  assign res_cancel_en_o               = cfg1_q[mta_pkg::CFG1_RES];
  assign beta_comp_en_o                = cfg1_q[mta_pkg::CFG1_BETA];
endmodule : mta_core

// *** mta_core_asserts.sv ***
// port assertions of the temperature alarm core
`timescale 1ns/1ps
module mta_core_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       conv_clk_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       alert_n_o,
  input wire logic       alert_oe_o,
  input wire logic       overtemp_shutdown_output_n_o,
  input wire logic       overtemp_shutdown_output_oe_o,
  input wire logic       res_cancel_en_o,
  input wire logic       beta_comp_en_o,
  input wire logic       adc_start_o,
  input wire logic [2:0] adc_chan_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pins_low: assert property (!sda_o && !alert_n_o
    && !overtemp_shutdown_output_n_o) else $error("pin value high");
  a_reset_state: assert property ($fell(rst_i) |-> !sda_oe_o
    && !alert_oe_o && !overtemp_shutdown_output_oe_o && res_cancel_en_o
    && beta_comp_en_o) else $error("outputs wrong after reset");
  a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved with clock high");
  a_ack_stands: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("data bit too short");
  a_cfg_scl_low: assert property ($changed({res_cancel_en_o,
    beta_comp_en_o}) |-> !scl_i) else $error("config moved, clock high");
  a_start_pulse: assert property (@(posedge conv_clk_i) disable iff
    (rst_i) adc_start_o |=> !adc_start_o) else $error("start too long");
  a_chan_hold: assert property (@(posedge conv_clk_i) disable iff
    (rst_i) adc_start_o |=> $stable(adc_chan_o) [*3])
    else $error("channel moved after start");
  a_chan_range: assert property (@(posedge conv_clk_i) disable iff
    (rst_i) adc_start_o |-> adc_chan_o <= 3'h6) else $error("bad channel");
  c_alert: cover property ($rose(alert_oe_o));
  c_ot: cover property ($rose(overtemp_shutdown_output_oe_o));
  c_clear: cover property ($fell(alert_oe_o));
endmodule : mta_core_asserts
bind mta_core mta_core_asserts u_asrt (.clk_i, .rst_i, .conv_clk_i, .scl_i,
  .sda_o, .sda_oe_o, .alert_n_o, .alert_oe_o, .overtemp_shutdown_output_n_o,
  .overtemp_shutdown_output_oe_o, .res_cancel_en_o, .beta_comp_en_o,
  .adc_start_o, .adc_chan_o);

// *** mta_core_tb.sv ***
// bench of the temperature alarm core
`timescale 1ns/1ps
module mta_core_tb;
  localparam logic [15:0] TBL [16] = '{16'h410c, 16'h4200, 16'h4300,
    16'h175a, 16'h116e, 16'h127f, 16'h216e, 16'h247f, 16'h255a, 16'h265a,
    16'h0760, 16'h027f, 16'h0300, 16'h05ff, 16'h0650, 16'h3000};
  logic            clk_i;
  logic            conv_clk_i;
  logic            rst_i;
  logic            done;
  logic            flt;
  logic [11:0]     adat;
  logic [11:0]     tv [7];
  logic [10:0]     r1;
  logic [7:0]      exp_q [$];
  int              bad_count;
  int              cmp_count;
  wire logic       scl;
  wire logic       hoe;
  wire logic       sda_oe;
  wire logic       rd_v;
  wire logic       start;
  wire logic [7:0] rd_q;
  wire logic [1:0] lv;
  wire logic [1:0] en;
  wire logic [2:0] chan;
  wire logic       sda = !(hoe | sda_oe);
  mta_core #(.FAULT_CYC(50), .TMO_CYC(2000)) dut (.clk_i, .rst_i,
    .ce_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .alert_n_o(), .alert_oe_o(lv[0]), .overtemp_shutdown_output_n_o(),
    .overtemp_shutdown_output_oe_o(lv[1]), .res_cancel_en_o(en[1]),
    .beta_comp_en_o(en[0]), .conv_clk_i, .adc_start_o(start),
    .adc_chan_o(chan), .adc_done_i(done), .adc_data_i(adat),
    .adc_fault_i(flt));
  mta_host h (.clk_i, .sda_i(sda), .scl_o(scl), .sda_oe_o(hoe),
    .rd_v_o(rd_v), .rd_q_o(rd_q));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    conv_clk_i = 1'b0;
    #3.3;
    forever #7.5 conv_clk_i = ~conv_clk_i;
  end
  always @(posedge conv_clk_i) begin
    done <= start;
    adat <= tv[chan];
    flt <= chan == 3'h5;
  end
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  always @(posedge clk_i) begin
    if (rd_v === 1'b1) chk("read", rd_q, exp_q.pop_front());
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic rq(input logic [7:0] a, e, input logic r = 1'b0,
                    input logic [6:0] sa = 7'h2a);
    exp_q.push_back(e);
    h.rd(a, r, sa);
  endtask : rq
  task automatic lvl(input int k, input logic e);
    logic [1:0] v;
    for (int n = 0; n < 2000; n++) begin
      v = lv;
      if (v[k] === e) break;
      @(posedge clk_i);
    end
    chk(k ? "overtemp" : "alert", {7'h00, v[k]}, {7'h00, e});
    if (v[k] !== e) end_sim();
  endtask : lvl
  initial begin
    rst_i = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    r1 = 11'($urandom(13679));
    r1 = 11'($urandom % 768);
    tv = '{12'h300, {1'b0, r1}, 12'h640, 12'hfd8, 12'h180, 12'h0, 12'h280};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rq(8'h00, 8'h00, 1'b1);
    foreach (TBL[i]) rq(TBL[i][15:8], TBL[i][7:0]);
    rq(8'h09, {r1[2:0], 5'h00});
    // new channel 1 value must stay hidden until its main byte is read
    tv[1] = 12'h308;
    rq(8'h01, r1[10:3]);
    lvl(0, 1'b1);
    lvl(1, 1'b0);
    h.wr(8'h41, 8'h8c);
    rq(8'h44, 8'h40);
    lvl(0, 1'b0);
    rq(8'h44, 8'h00);
    h.wr(8'h41, 8'h0c);
    lvl(0, 1'b1);
    h.wr(8'h41, 8'h8c);
    rq(8'h00, 8'h54, 1'b1, 7'h0c);
    lvl(0, 1'b0);
    h.wr(8'h42, 8'h40);
    rq(8'h00, 8'h40, 1'b1);
    h.wr(8'h41, 8'h0c);
    rq(8'h44, 8'h40);
    lvl(0, 1'b0);
    h.wr(8'h26, 8'h40);
    lvl(1, 1'b1);
    h.wr(8'h26, 8'h52);
    rq(8'h06, 8'h50);
    lvl(1, 1'b1);
    h.wr(8'h43, 8'h20);
    lvl(1, 1'b0);
    h.wr(8'h43, 8'h00);
    lvl(1, 1'b1);
    h.wr(8'h26, 8'h55);
    lvl(1, 1'b0);
    h.wr(8'h41, 8'h08);
    chk("config", {6'h00, en}, 8'h02);
    h.wr(8'h41, 8'h48);
    chk("config", {6'h00, en}, 8'h03);
    rq(8'h41, 8'h0c);
    rq(8'h26, 8'h5a);
    repeat (10) @(posedge clk_i);
    end_sim();
  end
endmodule : mta_core_tb

// *** mta_host.sv ***
// two-wire bus host model: bit-banged clock and open-drain data
`timescale 1ns/1ps
module mta_host (
  input  wire logic  clk_i,
  input  wire logic  sda_i,
  output logic       scl_o,
  output logic       sda_oe_o,
  output logic       rd_v_o,
  output logic [7:0] rd_q_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_v_o = 1'b0;
  end
  task automatic st(input logic c, input logic o);
    scl_o <= c;
    sda_oe_o <= o;
    repeat (8) @(posedge clk_i);
  endtask : st
  // start when o is high, stop when low
  task automatic cond(input logic o);
    st(1'b0, sda_oe_o);
    st(1'b0, !o);
    st(1'b1, !o);
    st(1'b1, o);
  endtask : cond
  // eight data bits then the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [7:0] q);
    logic [8:0] s;
    for (int i = 8; i >= 0; i--) begin
      st(1'b0, sda_oe_o);
      st(1'b0, !d[i]);
      st(1'b1, !d[i]);
      s[i] = sda_i;
    end
    q = s[8:1];
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    cond(1'b1);
    xfer({7'h2a, 2'b01}, q);
    xfer({a, 1'b1}, q);
    xfer({v, 1'b1}, q);
    cond(1'b0);
  endtask : wr
  // pointer set first unless a receive byte
  task automatic rd(input logic [7:0] a, input logic rcv,
                    input logic [6:0] sa);
    logic [7:0] q;
    cond(1'b1);
    if (!rcv) begin
      xfer({sa, 2'b01}, q);
      xfer({a, 1'b1}, q);
      cond(1'b1);
    end
    xfer({sa, 2'b11}, q);
    xfer(9'h1ff, q);
    cond(1'b0);
    rd_q_o <= q;
    rd_v_o <= 1'b1;
    @(posedge clk_i);
    rd_v_o <= 1'b0;
  endtask : rd
endmodule : mta_host

// *** mta_pkg.sv ***
// shared constants and carrier types of the temperature alarm core
package mta_pkg;
  localparam int         NCH         = 7;
  localparam int         ADC_W       = 12;
  localparam int         CNT_W       = 21;
  localparam int         CLK_HZ      = 50_000_000;
  localparam int         FAULT_MS    = 4;
  localparam int         BUS_TMO_MS  = 37;
  localparam int         FAULT_CYC   = CLK_HZ / 1000 * FAULT_MS;
  localparam int         BUS_TMO_CYC = CLK_HZ / 1000 * BUS_TMO_MS;
  localparam logic [6:0] ARA_ADDR    = 7'h0c;
  // register groups: bits 7:3 of the pointer, slot in bits 2:0
  localparam logic [4:0] GRP_TEMP    = 5'h00;
  localparam logic [4:0] GRP_ALIM    = 5'h02;
  localparam logic [4:0] GRP_OLIM    = 5'h04;
  localparam logic [2:0] LOCAL_SLOT  = 3'h7;
  localparam logic [7:0] A_TEMP1     = 8'h01;
  localparam logic [7:0] A_EXT       = 8'h09;
  localparam logic [7:0] A_MFR       = 8'h0a;
  localparam logic [7:0] A_CFG1      = 8'h41;
  localparam logic [7:0] A_CFG2      = 8'h42;
  localparam logic [7:0] A_CFG3      = 8'h43;
  localparam logic [7:0] A_ST1       = 8'h44;
  localparam logic [7:0] A_ST2       = 8'h45;
  localparam logic [7:0] A_ST3       = 8'h46;
  localparam logic [7:0] PTR_RST     = 8'h00;
  localparam logic [7:0] CFG1_RST    = 8'h0c;
  localparam logic [7:0] CFG2_RST    = 8'h00;
  localparam logic [7:0] CFG3_RST    = 8'h00;
  localparam logic [7:0] CFG1_MASK   = 8'hac;
  localparam logic [7:0] CFG2_MASK   = 8'h7f;
  localparam logic [7:0] CFG3_MASK   = 8'h39;
  localparam int         CFG1_STOP   = 7;
  localparam int         CFG1_POR    = 6;
  localparam int         CFG1_TMO    = 5;
  localparam int         CFG1_RES    = 3;
  localparam int         CFG1_BETA   = 2;
  localparam logic [7:0] TEMP_RST    = 8'h00;
  localparam logic [7:0] TEMP_MAX    = 8'h7f;
  localparam logic [7:0] TEMP_MIN    = 8'h00;
  localparam logic [7:0] TEMP_FAULT  = 8'hff;
  localparam logic [8:0] OT_HYST     = 9'h004;
  localparam logic [6:0] OT_CHANS    = 7'h72;
  // index 0 is the local channel, index k is remote k
  localparam logic [NCH-1:0][7:0] ALIM_RST =
    {8'h64, 8'h64, 8'h64, 8'h64, 8'h7f, 8'h6e, 8'h5a};
  localparam logic [NCH-1:0][7:0] OLIM_RST =
    {8'h5a, 8'h5a, 8'h7f, 8'h00, 8'h00, 8'h6e, 8'h00};

  typedef struct packed {
    logic       ptr_wr;
    logic       data_wr;
    logic       rd_done;
    logic       ara_won;
    logic [7:0] data;
  } mta_smb_evt_t;

  typedef struct packed {
    logic [ADC_W-1:0] data;
    logic             fault;
  } mta_conv_t;
endpackage : mta_pkg

// *** mta_smb_slave.sv ***
// two-wire byte slave with alert response arbitration
`timescale 1ns/1ps
module mta_smb_slave #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,
  parameter int         TMO_CYC    = mta_pkg::BUS_TMO_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output wire logic                  sda_o,
  output wire logic                  sda_oe_o,
  input  wire logic                  tmo_en_i,
  input  wire logic                  alert_i,
  input  wire logic [7:0]            rd_data_i,
  output mta_pkg::mta_smb_evt_t      evt_o
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001, S_ADDR = 7'b0000010, S_AACK = 7'b0000100,
    S_RX   = 7'b0001000, S_RACK = 7'b0010000, S_TX   = 7'b0100000,
    S_TACK = 7'b1000000
  } mta_smb_st_t;

  mta_smb_st_t               st_q;
  mta_pkg::mta_smb_evt_t     evt_q;
  logic [1:0]                scl_ff_q, sda_ff_q;
  logic                      scl_q, sda_q, oe_q, rw_q, ara_q, lost_q;
  logic                      got_cmd_q, acked_q;
  logic [3:0]                cnt_q;
  logic [7:0]                sh_q, tx_q;
  logic [mta_pkg::CNT_W-1:0] tmo_q;
  logic                      scl, sda, start, stop, rise, fall, tmo_hit;

  assign scl   = scl_ff_q[1];
  assign sda   = sda_ff_q[1];
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign rise  = scl & ~scl_q;
  assign fall  = ~scl & scl_q;
  assign tmo_hit = tmo_q == mta_pkg::CNT_W'(TMO_CYC - 1);
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;
  assign evt_o    = evt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_ff_q <= 2'b11;
      sda_ff_q <= 2'b11;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else if (ce_i) begin
      scl_ff_q <= {scl_ff_q[0], scl_i};
      sda_ff_q <= {sda_ff_q[0], sda_i};
      scl_q    <= scl;
      sda_q    <= sda;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_q <= '0;
    end else if (ce_i) begin
      if (scl || st_q == S_IDLE || !tmo_en_i || tmo_hit) tmo_q <= '0;
      else tmo_q <= tmo_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      evt_q <= '0;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      lost_q <= 1'b0;
      got_cmd_q <= 1'b0;
      acked_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
    end else if (ce_i) begin
      evt_q.ptr_wr  <= 1'b0;
      evt_q.data_wr <= 1'b0;
      evt_q.rd_done <= 1'b0;
      evt_q.ara_won <= 1'b0;
      if (stop || tmo_hit) begin
        st_q <= S_IDLE;
        oe_q <= 1'b0;
      end else if (start) begin
        st_q <= S_ADDR;
        oe_q <= 1'b0;
        cnt_q <= 4'h0;
        got_cmd_q <= 1'b0;
        ara_q <= 1'b0;
        lost_q <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end
            if (fall && cnt_q == 4'h8) begin
              if (sh_q[7:1] == SLAVE_ADDR) begin
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= S_AACK;
              end else if (sh_q[7:1] == mta_pkg::ARA_ADDR && sh_q[0] &&
                           alert_i) begin
                oe_q <= 1'b1;
                rw_q <= 1'b1;
                ara_q <= 1'b1;
                st_q <= S_AACK;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_AACK: if (fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              tx_q <= ara_q ? {SLAVE_ADDR, 1'b0} : rd_data_i;
              oe_q <= ara_q ? ~SLAVE_ADDR[6] : ~rd_data_i[7];
              st_q <= S_TX;
            end else begin
              oe_q <= 1'b0;
              st_q <= S_RX;
            end
          end
          S_RX: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end
            // first byte sets pointer, later bytes write
            if (fall && cnt_q == 4'h8) begin
              oe_q <= 1'b1;
              st_q <= S_RACK;
              evt_q.data <= sh_q;
              evt_q.ptr_wr <= ~got_cmd_q;
              evt_q.data_wr <= got_cmd_q;
              got_cmd_q <= 1'b1;
            end
          end
          S_RACK: if (fall) begin
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= S_RX;
          end
          S_TX: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
              if (ara_q && tx_q[7] && !sda) lost_q <= 1'b1;
            end
            if (fall) begin
              if (cnt_q == 4'h8) begin
                oe_q <= 1'b0;
                st_q <= S_TACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= ~tx_q[6] & ~lost_q;
              end
            end
          end
          S_TACK: begin
            if (rise) begin
              acked_q <= ~sda;
              evt_q.rd_done <= ~ara_q;
              evt_q.ara_won <= ara_q & ~lost_q;
            end
            if (fall) begin
              if (acked_q && !ara_q) begin
                tx_q <= rd_data_i;
                oe_q <= ~rd_data_i[7];
                cnt_q <= 4'h0;
                st_q <= S_TX;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule : mta_smb_slave
